// [verilog/pvc_core.sv]
// pin verify, change, disable (plus unblock) command logic with an apb slave
// assumes a transport layer loads the command fields over apb and reads the status word
//
// Operation
// - verify compares only when pin neither disabled nor blocked
// - correct verify restores the tries counter to three
// - wrong verify decrements that pin's tries counter
// - third wrong presentation blocks the pin and answers 63c0
// - verify on a blocked pin answers 6983 with no comparison
// - pin-protected access needs successful verification unless pin is disabled
// - blocked pin makes dependent access unsatisfiable until unblocked
// - verify with empty data answers 63cx with tries left
// - failed compare on unblocked pin reports tries left as 63cx
// - p2: bit8 global/specific, bits7-6 zero, ref 01..1f, zero unsupported
// - verify has p1 zero and data empty or eight bytes
// - change runs only when pin neither disabled nor blocked
// - correct old pin resets tries and stores the new pin
// - wrong old pin decrements, keeps pin, blocks after three
// - disable refused when pin already disabled or blocked
// - correct disable resets tries and marks pin disabled
// - wrong disable decrements, stays enabled, blocks after three
// - disabled pin makes protected files always accessible unless replaced
// - replacement key gets qualifier 08 and must itself be verified
// - files naming several global keys become unconditional after a disable
// - disable p1: 00 plain, 01 reserved, bit8 replacement key 01..1f
// - unblock restores tries to three, sets new pin, leaves pin enabled
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_regs.svh"
module pvc_core #(
    parameter int NPIN = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // pin storage is flip-flops; a real card keeps it non-volatile, so the
    // tries counter here goes back to three at every presetn reset, not only at power loss
    pvc_pkg::pvc_pin_t pin_q [NPIN];
    logic [63:0] ref_q [NPIN];
    logic [7:0] qual_q [NPIN];
    logic [4:0] repl_q [NPIN];
    logic [31:0] cmd_q, p1_q, p2_q, lc_q, dlo_q, dhi_q, nlo_q, nhi_q, acc_q, sel_q;
    logic [15:0] sw_q;
    logic busy_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup = psel && !penable;
    wire wr_go = setup && pwrite;
    wire rd_go = setup && !pwrite;
    wire [11:0] a = paddr;
    wire hit = (a == `PVC_OFF_CMD) || (a == `PVC_OFF_P1) || (a == `PVC_OFF_P2)
        || (a == `PVC_OFF_LC) || (a == `PVC_OFF_DLO) || (a == `PVC_OFF_DHI)
        || (a == `PVC_OFF_NLO) || (a == `PVC_OFF_NHI) || (a == `PVC_OFF_SW)
        || (a == `PVC_OFF_STAT) || (a == `PVC_OFF_ACC) || (a == `PVC_OFF_SEL)
        || (a == `PVC_OFF_KEY);
    wire ro_hit = (a == `PVC_OFF_SW) || (a == `PVC_OFF_STAT) || (a == `PVC_OFF_ACC)
        || (a == `PVC_OFF_KEY);
    wire wr_ok = wr_go && hit && !ro_hit && !busy_q;
    // a write while busy is refused, so a new go never lands on a running command
    wire go = wr_ok && (a == `PVC_OFF_CMD) && pwdata[`PVC_GO_BIT];
    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    wire [1:0] op = cmd_q[1:0];
    wire [7:0] p1 = p1_q[7:0];
    wire [7:0] p2 = p2_q[7:0];
    wire [7:0] lc = lc_q[7:0];
    wire [4:0] idx = p2[4:0];
    wire p2_ok = (p2 != 8'h00) && (p2[6:5] == 2'b00) && (p2[4:0] != 5'h00);
    wire is_ver = (op == pvc_pkg::PVC_OP_VERIFY);
    wire is_chg = (op == pvc_pkg::PVC_OP_CHANGE);
    wire is_dis = (op == pvc_pkg::PVC_OP_DISABLE);
    wire is_unb = (op == pvc_pkg::PVC_OP_UNBLOCK);
    wire dis_repl = p1[`PVC_REF_SPEC];
    wire p1_ok = is_dis ? ((p1 == 8'h00) || (dis_repl && p1[6:5] == 2'b00
        && p1[4:0] != 5'h00)) : (p1 == 8'h00);
    wire ver_empty = is_ver && (lc == 8'h00);
    wire len_ok = is_ver ? (lc == 8'h00 || lc == `PVC_LEN_PIN) :
        (is_dis ? (lc == `PVC_LEN_PIN) : (lc == `PVC_LEN_TWO));
    pvc_pkg::pvc_pin_t cur;
    assign cur = pin_q[idx];
    // compares all eight bytes at once; no byte of the pin is masked
    wire match = (ref_q[idx] == {dhi_q, dlo_q});
    // a slot reaches zero tries only as it blocks, so dec never wraps
    wire last_try = (cur.tries == 2'h1);
    wire [1:0] dec = cur.tries - 2'h1;
    // ----------------------------------------------------------------
    // access evaluation
    // ----------------------------------------------------------------
    pvc_pkg::pvc_pin_t ap;
    assign ap = pin_q[sel_q[4:0]];
    wire [4:0] rk = repl_q[sel_q[4:0]];
    wire repl_used = (qual_q[sel_q[4:0]] == `PVC_QUAL_USE);
    wire multi = sel_q[8];
    // access is registered: it follows a new select or pin state one cycle late
    wire acc_d = ap.blk ? 1'b0 :
        !ap.dis ? ap.ver :
        multi ? 1'b1 :
        repl_used ? (pin_q[rk].ver && !pin_q[rk].blk) : 1'b1;
    // ----------------------------------------------------------------
    // command execution
    // ----------------------------------------------------------------
    logic [15:0] sw_d;
    pvc_pkg::pvc_pin_t nxt;
    logic store_new, set_qual;
    always_comb begin
        sw_d = `PVC_SW_OK;
        nxt = cur;
        store_new = 1'b0;
        set_qual = 1'b0;
        if (!p2_ok || !p1_ok) begin
            sw_d = `PVC_SW_P1P2;
        end else if (!len_ok && !(is_unb && lc == 8'h00)) begin
            sw_d = `PVC_SW_LEN;
        end else if (is_unb) begin
            // unblock counter of its own lies elsewhere; data is not compared, the new pin words are stored
            if (lc != 8'h00) begin
                nxt.tries = `PVC_TRIES_INIT;
                nxt.blk = 1'b0;
                nxt.dis = 1'b0;
                nxt.ver = 1'b1;
                store_new = 1'b1;
            end
        end else if (cur.blk) begin
            sw_d = is_ver ? `PVC_SW_BLOCKED : `PVC_SW_COND;
        end else if (ver_empty) begin
            sw_d = {`PVC_SW_RETRY, 2'b00, cur.tries};
        end else if (cur.dis) begin
            sw_d = `PVC_SW_COND;
        end else if (match) begin
            nxt.tries = `PVC_TRIES_INIT;
            // only a verify sets ver here; a good change or disable clears it
            nxt.ver = is_ver;
            if (is_chg) begin
                store_new = 1'b1;
            end
            if (is_dis) begin
                nxt.dis = 1'b1;
                set_qual = dis_repl;
            end
        end else begin
            nxt.tries = dec;
            nxt.ver = 1'b0;
            if (last_try) begin
                nxt.blk = 1'b1;
            end
            sw_d = {`PVC_SW_RETRY, 2'b00, dec};
        end
    end
    wire exec = busy_q;
    wire commit = exec && p2_ok;
    // ----------------------------------------------------------------
    // per-pin storage
    // ----------------------------------------------------------------
    // slot zero exists but a legal p2 never addresses it
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            // a refused command writes its unchanged record back; only p2 gates this
            wire sel_me = commit && (idx == 5'(g));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_q[g] <= '{tries: `PVC_TRIES_INIT, dis: 1'b0, blk: 1'b0, ver: 1'b0};
                    ref_q[g] <= `PVC_RESET_PIN;
                    qual_q[g] <= `PVC_QUAL_NOUSE;
                    repl_q[g] <= 5'h00;
                end else if (sel_me) begin
                    pin_q[g] <= nxt;
                    if (store_new) begin
                        ref_q[g] <= {nhi_q, nlo_q};
                    end
                    if (set_qual) begin
                        qual_q[g] <= `PVC_QUAL_USE;
                        repl_q[g] <= p1[4:0];
                    end
                end
            end
        end
    endgenerate
    // ----------------------------------------------------------------
    // command registers and sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= 32'h0000_0000;
            p1_q <= 32'h0000_0000;
            p2_q <= 32'h0000_0000;
            lc_q <= 32'h0000_0000;
            dlo_q <= 32'h0000_0000;
            dhi_q <= 32'h0000_0000;
            nlo_q <= 32'h0000_0000;
            nhi_q <= 32'h0000_0000;
            sel_q <= 32'h0000_0000;
            busy_q <= 1'b0;
            sw_q <= `PVC_SW_OK;
        end else begin
            busy_q <= go;
            if (exec) begin
                sw_q <= sw_d;
            end
            if (wr_ok) begin
                case (a)
                    `PVC_OFF_CMD: cmd_q <= {1'b0, pwdata[30:0]};
                    `PVC_OFF_P1: p1_q <= pwdata;
                    `PVC_OFF_P2: p2_q <= pwdata;
                    `PVC_OFF_LC: lc_q <= pwdata;
                    `PVC_OFF_DLO: dlo_q <= pwdata;
                    `PVC_OFF_DHI: dhi_q <= pwdata;
                    `PVC_OFF_NLO: nlo_q <= pwdata;
                    `PVC_OFF_NHI: nhi_q <= pwdata;
                    `PVC_OFF_SEL: sel_q <= pwdata;
                    default: ;
                endcase
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 32'h0000_0000;
        end else begin
            acc_q <= {31'h0000_0000, acc_d};
        end
    end
    // ----------------------------------------------------------------
    // apb answer: no wait state, registered
    // ----------------------------------------------------------------
    // presented and new pin words read back as zero, so software cannot fetch them
    logic [31:0] rd_mux;
    assign rd_mux =
        (a == `PVC_OFF_CMD) ? {31'h0000_0000, busy_q} :
        (a == `PVC_OFF_P1) ? p1_q :
        (a == `PVC_OFF_P2) ? p2_q :
        (a == `PVC_OFF_LC) ? lc_q :
        (a == `PVC_OFF_SW) ? {16'h0000, sw_q} :
        (a == `PVC_OFF_STAT) ? {27'h0000000, pin_q[sel_q[4:0]]} :
        (a == `PVC_OFF_ACC) ? acc_q :
        (a == `PVC_OFF_SEL) ? sel_q :
        (a == `PVC_OFF_KEY) ? {19'h00000, repl_q[sel_q[4:0]], qual_q[sel_q[4:0]]} :
        32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && (!hit || (pwrite && (ro_hit || busy_q)));
            prdata_q <= (rd_go && hit) ? rd_mux : 32'h0000_0000;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_block_on_third: assert property (
        exec && p2_ok && !is_unb && !cur.blk && !cur.dis && !match && !ver_empty
        && len_ok && p1_ok && last_try |=> sw_q == {`PVC_SW_RETRY, 4'h0} && pin_q[$past(idx)].blk)
        else $error("third failure did not block");
    a_blocked_verify: assert property (
        exec && p2_ok && p1_ok && len_ok && is_ver && cur.blk |=> sw_q == `PVC_SW_BLOCKED)
        else $error("blocked verify not 6983");
    a_good_restores: assert property (
        exec && p2_ok && p1_ok && len_ok && !is_unb && !cur.blk && !cur.dis && match
        && !ver_empty |=> pin_q[$past(idx)].tries == `PVC_TRIES_INIT && sw_q == `PVC_SW_OK)
        else $error("good pin did not restore");
    a_bad_decrements: assert property (
        exec && p2_ok && p1_ok && len_ok && !is_unb && !cur.blk && !cur.dis && !match
        && !ver_empty |=> pin_q[$past(idx)].tries == $past(cur.tries) - 2'h1)
        else $error("bad pin did not decrement");
    a_retry_query: assert property (
        exec && p2_ok && p1_ok && ver_empty && !cur.blk |=> sw_q[15:4] == `PVC_SW_RETRY
        && sw_q[1:0] == $past(cur.tries)) else $error("retry query wrong");
    a_p2_zero: assert property (
        exec && p2 == 8'h00 |=> sw_q == `PVC_SW_P1P2) else $error("p2 zero accepted");
    a_dis_refused: assert property (
        exec && p2_ok && p1_ok && len_ok && is_dis && (cur.dis || cur.blk)
        |=> sw_q != `PVC_SW_OK) else $error("disable not refused");
    a_blocked_access: assert property (
        ap.blk |=> acc_q[0] == 1'b0) else $error("blocked pin gave access");
    a_unblock_restores: assert property (
        exec && p2_ok && p1_ok && is_unb && lc == `PVC_LEN_TWO |=> !pin_q[$past(idx)].blk
        && !pin_q[$past(idx)].dis && pin_q[$past(idx)].tries == `PVC_TRIES_INIT)
        else $error("unblock incomplete");
    a_apb_wait: assert property (
        setup |=> pready ##1 !pready) else $error("apb answer timing");
    // shorthand for a well-formed pin command, and for one that reaches the compare
    wire chk_legal = exec && p2_ok && p1_ok && len_ok && !is_unb;
    wire chk_live = chk_legal && !cur.blk && !cur.dis && !ver_empty;
    a_disabled_no_compare: assert property (
        chk_legal && is_ver && !ver_empty && cur.dis && !cur.blk
        |=> sw_q == `PVC_SW_COND && pin_q[$past(idx)].tries == $past(cur.tries))
        else $error("disabled pin was compared");
    a_fail_status: assert property (
        chk_live && !match |=> sw_q == {`PVC_SW_RETRY, 2'b00, $past(cur.tries) - 2'h1})
        else $error("failed compare status wrong");
    a_needs_verify: assert property (
        !ap.blk && !ap.dis |=> acc_q[0] == $past(ap.ver))
        else $error("access ignores verification");
    a_verify_marks: assert property (
        chk_live && is_ver && match |=> pin_q[$past(idx)].ver)
        else $error("good verify not recorded");
    a_change_refused: assert property (
        chk_legal && is_chg && (cur.dis || cur.blk) |=> sw_q == `PVC_SW_COND)
        else $error("change not refused");
    a_change_stores: assert property (
        chk_live && is_chg && match |=> ref_q[$past(idx)] == $past({nhi_q, nlo_q}))
        else $error("new pin not stored");
    a_change_keeps: assert property (
        chk_live && is_chg && !match |=> ref_q[$past(idx)] == $past(ref_q[idx]))
        else $error("wrong old pin changed the reference");
    a_disable_marks: assert property (
        chk_live && is_dis && match |=> pin_q[$past(idx)].dis)
        else $error("disable did not mark the pin");
    a_wrong_disable: assert property (
        chk_live && is_dis && !match |=> !pin_q[$past(idx)].dis)
        else $error("wrong pin disabled the slot");
    a_disabled_open: assert property (
        ap.dis && !ap.blk && !repl_used |=> acc_q[0])
        else $error("disabled pin still guards access");
    a_repl_marks: assert property (
        chk_live && is_dis && match && dis_repl |=> qual_q[$past(idx)] == `PVC_QUAL_USE
        && repl_q[$past(idx)] == $past(p1[4:0]))
        else $error("replacement key not marked");
    a_multi_open: assert property (
        ap.dis && !ap.blk && multi |=> acc_q[0])
        else $error("several keys still guarded");
    a_ok_status: assert property (
        chk_live && match |=> sw_q == `PVC_SW_OK)
        else $error("success not 9000");
    a_p1_refused: assert property (
        exec && !p1_ok |=> sw_q == `PVC_SW_P1P2)
        else $error("bad p1 accepted");
    a_len_refused: assert property (
        exec && p2_ok && p1_ok && !len_ok && !is_unb |=> sw_q == `PVC_SW_LEN)
        else $error("bad length accepted");
    a_unblock_empty: assert property (
        exec && p2_ok && p1_ok && is_unb && lc == 8'h00
        |=> sw_q == `PVC_SW_OK && pin_q[$past(idx)] == $past(cur))
        else $error("empty unblock changed the pin");
    a_busy_pulse: assert property (
        busy_q |=> !busy_q) else $error("busy longer than one cycle");
    a_bad_write_err: assert property (
        setup && pwrite && (ro_hit || !hit) |=> pslverr)
        else $error("bad write not flagged");
    c_block: cover property (exec && sw_d == {`PVC_SW_RETRY, 4'h0});
    c_retry_query: cover property (exec && ver_empty && !cur.blk);
    c_disable_ok: cover property (exec && is_dis && sw_d == `PVC_SW_OK);
    c_change_ok: cover property (exec && is_chg && sw_d == `PVC_SW_OK);
    c_repl_access: cover property (ap.dis && repl_used && acc_d);
endmodule : pvc_core
`default_nettype wire

// [verilog/pvc_regs.svh]
// register offsets, field positions and constants for the pin command block
// assumes inclusion from the package and the design file by bare name
`ifndef PVC_REGS_SVH
`define PVC_REGS_SVH
`define PVC_OFF_CMD 12'h000
`define PVC_OFF_P1 12'h004
`define PVC_OFF_P2 12'h008
`define PVC_OFF_LC 12'h00c
`define PVC_OFF_DLO 12'h010
`define PVC_OFF_DHI 12'h014
`define PVC_OFF_NLO 12'h018
`define PVC_OFF_NHI 12'h01c
`define PVC_OFF_SW 12'h020
`define PVC_OFF_STAT 12'h024
`define PVC_OFF_ACC 12'h028
`define PVC_OFF_SEL 12'h02c
`define PVC_OFF_KEY 12'h030
`define PVC_TRIES_INIT 2'h3
`define PVC_LEN_PIN 8'h08
`define PVC_LEN_TWO 8'h10
`define PVC_SW_OK 16'h9000
`define PVC_SW_RETRY 12'h63c
`define PVC_SW_BLOCKED 16'h6983
`define PVC_SW_COND 16'h6985
`define PVC_SW_P1P2 16'h6a86
`define PVC_SW_LEN 16'h6700
`define PVC_SW_REFND 16'h6a88
`define PVC_SW_INS 16'h6d00
`define PVC_QUAL_USE 8'h08
`define PVC_QUAL_NOUSE 8'h00
`define PVC_REF_SPEC 7
`define PVC_GO_BIT 31
`define PVC_RESET_PIN 64'h0000_0000_0000_0000
`endif

// [verilog/pvc_pkg.sv]
// types shared by the pin command block
// assumes pvc_regs.svh sits on the include path
`include "pvc_regs.svh"
package pvc_pkg;
    typedef enum logic [1:0] {
        PVC_OP_VERIFY = 2'b00,
        PVC_OP_CHANGE = 2'b01,
        PVC_OP_DISABLE = 2'b10,
        PVC_OP_UNBLOCK = 2'b11
    } pvc_op_t;
    typedef enum logic [1:0] {
        PVC_ST_IDLE = 2'b00,
        PVC_ST_EXEC = 2'b01,
        PVC_ST_DONE = 2'b10
    } pvc_state_t;
    // per-pin record: tries left, disabled, blocked, verified this session
    typedef struct packed {
        logic [1:0] tries;
        logic dis;
        logic blk;
        logic ver;
    } pvc_pin_t;
endpackage : pvc_pkg

// [dv/pvc_term.sv]
// terminal model: apb master that loads command fields, starts a command, fetches status
// assumes it shares pclk with the pin command block and is entered just after an edge
`timescale 1ns/1ps
`default_nettype none
`include "pvc_regs.svh"
module pvc_term (
    // clock
    input wire logic pclk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // one idle edge first, so back-to-back calls never drive psel twice in a step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic hung);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        hung = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus must not keep showing the last word
        pwdata <= ~d;
    endtask : xfer
    // whole pin units: bytes 1-8 in the high word first, new pin likewise
    task automatic send(input logic [1:0] op, input logic [7:0] p1, input logic [7:0] p2,
                        input logic [7:0] lc, input logic [63:0] pin, input logic [63:0] npin,
                        output logic [15:0] sw, output logic fault);
        logic [31:0] q;
        logic e;
        logic h;
        logic [11:0] adr [7];
        logic [31:0] val [7];
        adr = '{`PVC_OFF_P1, `PVC_OFF_P2, `PVC_OFF_LC, `PVC_OFF_DLO, `PVC_OFF_DHI,
                `PVC_OFF_NLO, `PVC_OFF_NHI};
        val = '{{24'h0, p1}, {24'h0, p2}, {24'h0, lc}, pin[31:0], pin[63:32],
                npin[31:0], npin[63:32]};
        fault = 1'b0;
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, adr[i], val[i], q, e, h);
            fault = fault | e | h;
        end
        xfer(1'b1, `PVC_OFF_CMD, {1'b1, 29'h0, op}, q, e, h);
        fault = fault | e | h;
        xfer(1'b0, `PVC_OFF_SW, 32'h0, q, e, h);
        fault = fault | e | h;
        sw = q[15:0];
    endtask : send
endmodule : pvc_term
`default_nettype wire

// [dv/pin_verify_change_disable_test.sv]
// self-checking bench for the pin command block, driven through the terminal model
// assumes the reference pin of every slot is zero after reset
`timescale 1ns/1ps
`default_nettype none
`include "pvc_regs.svh"
module pin_verify_change_disable_test;
    localparam logic [1:0] VFY = pvc_pkg::PVC_OP_VERIFY;
    localparam logic [1:0] CHG = pvc_pkg::PVC_OP_CHANGE;
    localparam logic [1:0] DIS = pvc_pkg::PVC_OP_DISABLE;
    localparam logic [1:0] UNB = pvc_pkg::PVC_OP_UNBLOCK;
    localparam logic [63:0] NEWPIN = 64'h3132_3334_3536_3738;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] sw;
    logic flt;
    logic [31:0] q;
    int bad_count;
    int check_count;
    pvc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    pvc_term u_term (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic guard(input logic f);
        if (f !== 1'b0) begin
            chk("bus fault", 32'h0, {31'h0, f});
            results();
        end
    endtask : guard
    task automatic cmd(input logic [1:0] op, input logic [7:0] p1, input logic [7:0] p2,
                       input logic [7:0] lc, input logic [63:0] pin, input logic [15:0] exp);
        u_term.send(op, p1, p2, lc, pin, NEWPIN, sw, flt);
        guard(flt);
        chk("status word", {16'h0, exp}, {16'h0, sw});
    endtask : cmd
    // sel: bit8 marks a file naming several global keys, bits 4:0 the pin slot
    task automatic peek(input logic [11:0] a, input logic [8:0] sel, input logic [31:0] m,
                        input logic [31:0] exp);
        logic e;
        logic h;
        u_term.xfer(1'b1, `PVC_OFF_SEL, {23'h0, sel}, q, e, h);
        guard(e | h);
        u_term.xfer(1'b0, a, 32'h0, q, e, h);
        guard(e | h);
        chk("status field", exp, q & m);
    endtask : peek
    task automatic t_reset;
        peek(`PVC_OFF_STAT, 9'h002, 32'hffff_ffff, 32'h18);
        peek(`PVC_OFF_ACC, 9'h002, 32'h1, 32'h0);
        peek(`PVC_OFF_KEY, 9'h002, 32'hffff_ffff, 32'h0);
    endtask : t_reset
    task automatic t_verify;
        cmd(VFY, 8'h00, 8'h81, 8'h08, 64'h0, `PVC_SW_OK);
        peek(`PVC_OFF_STAT, 9'h001, 32'hffff_ffff, 32'h19);
        peek(`PVC_OFF_ACC, 9'h001, 32'h1, 32'h1);
        cmd(VFY, 8'h00, 8'h01, 8'h08, 64'h0, `PVC_SW_OK);
    endtask : t_verify
    task automatic t_block;
        cmd(VFY, 8'h00, 8'h83, 8'h08, NEWPIN, 16'h63c2);
        cmd(VFY, 8'h00, 8'h83, 8'h00, 64'h0, 16'h63c2);
        cmd(CHG, 8'h00, 8'h83, 8'h10, NEWPIN, 16'h63c1);
        cmd(VFY, 8'h00, 8'h83, 8'h08, 64'h0, `PVC_SW_OK);
        cmd(VFY, 8'h00, 8'h83, 8'h08, NEWPIN, 16'h63c2);
        cmd(CHG, 8'h00, 8'h83, 8'h10, NEWPIN, 16'h63c1);
        cmd(DIS, 8'h00, 8'h83, 8'h08, NEWPIN, 16'h63c0);
        peek(`PVC_OFF_STAT, 9'h003, 32'h1e, 32'h02);
        cmd(VFY, 8'h00, 8'h83, 8'h08, 64'h0, `PVC_SW_BLOCKED);
        peek(`PVC_OFF_STAT, 9'h003, 32'h1e, 32'h02);
        peek(`PVC_OFF_ACC, 9'h003, 32'h1, 32'h0);
        cmd(CHG, 8'h00, 8'h83, 8'h10, 64'h0, `PVC_SW_COND);
        cmd(DIS, 8'h00, 8'h83, 8'h08, 64'h0, `PVC_SW_COND);
        cmd(UNB, 8'h00, 8'h83, 8'h10, 64'h0, `PVC_SW_OK);
        peek(`PVC_OFF_STAT, 9'h003, 32'h1e, 32'h18);
        cmd(UNB, 8'h00, 8'h83, 8'h00, 64'h0, `PVC_SW_OK);
        cmd(VFY, 8'h00, 8'h83, 8'h08, NEWPIN, `PVC_SW_OK);
    endtask : t_block
    task automatic t_change;
        cmd(CHG, 8'h00, 8'h84, 8'h10, 64'h0, `PVC_SW_OK);
        cmd(VFY, 8'h00, 8'h84, 8'h08, 64'h0, 16'h63c2);
        cmd(VFY, 8'h00, 8'h84, 8'h08, NEWPIN, `PVC_SW_OK);
        peek(`PVC_OFF_STAT, 9'h004, 32'hffff_ffff, 32'h19);
    endtask : t_change
    task automatic t_disable;
        cmd(DIS, 8'h00, 8'h85, 8'h08, 64'h0, `PVC_SW_OK);
        peek(`PVC_OFF_STAT, 9'h005, 32'h1e, 32'h1c);
        peek(`PVC_OFF_ACC, 9'h005, 32'h1, 32'h1);
        cmd(DIS, 8'h00, 8'h85, 8'h08, 64'h0, `PVC_SW_COND);
        cmd(CHG, 8'h00, 8'h85, 8'h10, 64'h0, `PVC_SW_COND);
        cmd(VFY, 8'h00, 8'h85, 8'h08, NEWPIN, `PVC_SW_COND);
        peek(`PVC_OFF_STAT, 9'h005, 32'h1e, 32'h1c);
    endtask : t_disable
    task automatic t_replace;
        cmd(DIS, 8'h87, 8'h86, 8'h08, 64'h0, `PVC_SW_OK);
        peek(`PVC_OFF_KEY, 9'h006, 32'h1fff, 32'h0708);
        peek(`PVC_OFF_ACC, 9'h006, 32'h1, 32'h0);
        peek(`PVC_OFF_ACC, 9'h106, 32'h1, 32'h1);
        cmd(VFY, 8'h00, 8'h07, 8'h08, 64'h0, `PVC_SW_OK);
        peek(`PVC_OFF_ACC, 9'h006, 32'h1, 32'h1);
    endtask : t_replace
    // {op, p1, p2, lc, status}: malformed commands, five of them on slot 7, which t_replace left verified
    task automatic t_params;
        logic [47:0] tb [7];
        logic e;
        logic h;
        tb = '{48'h00_00_00_08_6a86, 48'h00_00_41_08_6a86, 48'h00_01_87_08_6a86,
               48'h02_01_87_08_6a86, 48'h02_c1_87_08_6a86, 48'h01_00_87_08_6700,
               48'h00_00_87_10_6700};
        foreach (tb[i]) begin
            cmd(tb[i][41:40], tb[i][39:32], tb[i][31:24], tb[i][23:16], 64'h0,
                tb[i][15:0]);
        end
        peek(`PVC_OFF_STAT, 9'h007, 32'h1e, 32'h18);
        u_term.xfer(1'b0, 12'h100, 32'h0, q, e, h);
        guard(h);
        chk("unmapped error", 32'h1, {31'h0, e});
        u_term.xfer(1'b1, `PVC_OFF_SW, 32'h0, q, e, h);
        guard(h);
        chk("read-only error", 32'h1, {31'h0, e});
    endtask : t_params
    initial begin
        bad_count = 0;
        check_count = 0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_verify();
        t_block();
        t_change();
        t_disable();
        t_replace();
        t_params();
        results();
    end
endmodule : pin_verify_change_disable_test
`default_nettype wire
